// ---- core/ttw_top.sv ----
`timescale 1ns/100ps
module ttw_top #(
   parameter int ERASE_CYCLES = ttw_pkg::ERASE_CYC,
   parameter int HOLDOFF_CYCLES = ttw_pkg::HOLDOFF_CYC,
   parameter int WIN_A_CYCLES = ttw_pkg::WIN_A_CYC,
   parameter int WIN_B_CYCLES = ttw_pkg::WIN_B_CYC,
   parameter int BIT_DIV = ttw_pkg::BIT_DIV_CYC
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic [ttw_pkg::BUS_AW-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic track_a_readback,
   output logic track_a_wr,
   output logic track_b_wr,
   output logic track_c_wr,
   output logic write_gate,
   output logic increase_lamp,
   output logic ok_lamp,
   output logic decrease_lamp
);
   import ttw_pkg::*;

   typedef struct packed {
      ttw_state_t st;
      logic sw;
      logic write_permit;
      logic timing_marks_active;
      logic [CNT_W-1:0] cnt;
      logic [CNT_W-1:0] div;
      logic [4:0] bitc;
      logic [5:0] word;
      logic [5:0] addr;
      logic [5:0] addr_sh;
      logic track_a_toggle_ff;
      logic track_b_toggle_ff;
      logic track_c_toggle_ff;
      logic op_start_clear;
      logic [2:0] sync;
      logic rb_lvl;
      logic track_a_pulse;
      logic [31:0] rdata;
   } ttw_wr_state_t;

   ttw_wr_state_t q;
   ttw_wr_state_t n;
   ttw_gap_if gif ();

   logic tick;
   logic start;
   logic block_end;
   logic final_sector_done;
   logic address_output_window;
   logic parity_slot;
   logic even_ones_flag;
   logic bit_count_decode_addr;
   logic bit_count_decode_data;
   logic stop;
   logic c_slot;
   logic [2:0] addr_idx;
   logic addr_bit;

   // ****************************************
   // Sector decode
   // ****************************************
   always_comb begin
      tick = (q.st == TTW_RUN) && (q.div == '0);
      start = reg_wr && (reg_addr == CTRL_OFS) && reg_wdata[CTRL_START_BIT] && reg_wdata[CTRL_SW_BIT];
      block_end = tick && (q.word == WORD_LAST) && (q.bitc == BIT_EOB);
      final_sector_done = block_end && q.timing_marks_active && (q.addr == ADDR_LAST);
      address_output_window = q.timing_marks_active && (((q.word == WORD_ADDR) && (q.bitc >= BIT_WIN_FIRST))
         || ((q.word == WORD_DATA) && (q.bitc <= BIT_WIN_LAST)));
      parity_slot = q.timing_marks_active && (q.word == WORD_DATA) && (q.bitc == BIT_PARITY);
      even_ones_flag = ~^q.addr;
      bit_count_decode_addr = q.timing_marks_active && (q.word == WORD_ADDR) && (q.bitc == BIT_ADDR_MARK);
      bit_count_decode_data = q.timing_marks_active && (q.word == WORD_DATA) && (q.bitc == BIT_DATA_MARK);
      stop = ((q.st == TTW_ERASE) || (q.st == TTW_RUN)) && (!q.sw || !q.write_permit || final_sector_done);

      // The slot decode below feeds only the checks; it rebuilds each track C bit from the counters.
      c_slot = q.timing_marks_active && (((q.word == WORD_ADDR) && (q.bitc >= BIT_SYNC_ONE))
         || ((q.word == WORD_DATA) && ((q.bitc <= BIT_WIN_LAST) || (q.bitc == BIT_PARITY))));
      addr_idx = (q.word == WORD_ADDR) ? 3'(q.bitc - BIT_WIN_FIRST) : 3'(q.bitc + 5'h04);
      addr_bit = |(q.addr & (6'h01 << addr_idx));
   end

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      n = q;
      n.op_start_clear = 1'b0;
      n.rdata = '0;
      // The read-back pin passes three flops; a level counts once the second and third agree.
      n.sync = {q.sync[1:0], track_a_readback};
      if (q.sync[1] == q.sync[2]) begin
         n.rb_lvl = q.sync[2];
      end
      // Read-back edges are ignored while writing, when the heads only see their own current.
      n.track_a_pulse = n.rb_lvl && !q.rb_lvl && (q.st != TTW_RUN) && (q.st != TTW_ERASE);
      if (reg_wr && (reg_addr == CTRL_OFS)) begin
         n.sw = reg_wdata[CTRL_SW_BIT];
      end
      unique case (q.st)
         TTW_IDLE: begin
         end
         TTW_ERASE: begin
            n.cnt = q.cnt + 1'b1;
            if (q.cnt == CNT_W'(ERASE_CYCLES - 1)) begin
               n.st = TTW_RUN;
               n.cnt = '0;
               n.div = '0;
            end
         end
         TTW_RUN: begin
            n.div = tick ? CNT_W'(BIT_DIV - 1) : q.div - 1'b1;
            if (tick) begin
               n.track_a_toggle_ff = ~q.track_a_toggle_ff;
               if (block_end) begin
                  n.bitc = '0;
                  n.word = '0;
                  n.timing_marks_active = 1'b1;
                  if (q.timing_marks_active) begin
                     n.addr = q.addr + 1'b1;
                  end
               end else if (q.bitc == BIT_LAST) begin
                  n.bitc = '0;
                  n.word = q.word + 1'b1;
               end else begin
                  n.bitc = q.bitc + 1'b1;
               end
               if (bit_count_decode_addr || bit_count_decode_data) begin
                  n.track_b_toggle_ff = ~q.track_b_toggle_ff;
               end
               if (q.timing_marks_active && (q.word == WORD_ADDR) && (q.bitc == BIT_SYNC_ONE)) begin
                  n.track_c_toggle_ff = ~q.track_c_toggle_ff;
                  n.addr_sh = q.addr;
               end
               if (address_output_window) begin
                  n.addr_sh = q.addr_sh >> 1;
                  if (q.addr_sh[0]) begin
                     n.track_c_toggle_ff = ~q.track_c_toggle_ff;
                  end
               end
               if (parity_slot && even_ones_flag) begin
                  n.track_c_toggle_ff = ~q.track_c_toggle_ff;
               end
            end
         end
         TTW_HOLD: begin
            n.cnt = q.cnt + 1'b1;
            if (q.cnt == CNT_W'(HOLDOFF_CYCLES - 1)) begin
               n.st = TTW_IDLE;
               n.cnt = '0;
            end
         end
         default: begin
            n.st = TTW_IDLE;
         end
      endcase
      // A tick that meets a stop still records its toggles, so the last bit is whole.
      if (stop) begin
         n.st = TTW_HOLD;
         n.write_permit = 1'b0;
         n.cnt = '0;
      end
      // Start comes last so that a restart always wins over a stop in the same cycle.
      if (start) begin
         n.st = TTW_ERASE;
         n.write_permit = 1'b1;
         n.op_start_clear = 1'b1;
         n.cnt = '0;
         n.div = '0;
         n.bitc = '0;
         n.word = '0;
         n.addr = '0;
         n.addr_sh = '0;
         n.timing_marks_active = 1'b0;
         n.track_a_toggle_ff = 1'b0;
         n.track_b_toggle_ff = 1'b0;
         n.track_c_toggle_ff = 1'b0;
      end
      if (reg_rd) begin
         unique case (reg_addr)
            CTRL_OFS: n.rdata = {31'h0, q.sw};
            STAT_OFS: n.rdata = {21'h0, q.st, gif.too_large, gif.in_range, gif.too_small, gif.seen,
                                 (q.st == TTW_HOLD), q.timing_marks_active, q.write_permit};
            POS_OFS: n.rdata = {10'h0, q.addr, 2'h0, q.word, 3'h0, q.bitc};
            default: n.rdata = '0;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         q <= '{st: TTW_IDLE, sw: CTRL_SW_RST, default: '0};
      end else begin
         q <= n;
      end
   end

   // ****************************************
   // Outputs and gap logic
   // ****************************************
   assign gif.op_clear = q.op_start_clear;
   assign gif.write_permit = q.write_permit;
   assign gif.holdoff_active = (q.st == TTW_HOLD);
   assign gif.track_a_pulse = q.track_a_pulse;

   ttw_gap_check #(
      .WIN_A_CYCLES(WIN_A_CYCLES),
      .WIN_B_CYCLES(WIN_B_CYCLES)
   ) u_gap (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .g(gif.gap)
   );

   assign reg_rdata = q.rdata;
   assign track_a_wr = q.track_a_toggle_ff;
   assign track_b_wr = q.track_b_toggle_ff;
   assign track_c_wr = q.track_c_toggle_ff;
   assign write_gate = q.write_permit && q.sw && ((q.st == TTW_ERASE) || (q.st == TTW_RUN));
   assign increase_lamp = gif.too_small;
   assign ok_lamp = gif.in_range;
   assign decrease_lamp = gif.too_large;

   // ****************************************
   // Checks
   // ****************************************
   AST_NO_WRITE_OFF: assert property (@(posedge core_clk) disable iff (!rst_b)
      !q.sw && !start |=> (q.st != TTW_RUN) && (q.st != TTW_ERASE))
      else $error("Writing continued with switch down.");
   AST_START_CLEAR: assert property (@(posedge core_clk) disable iff (!rst_b)
      start |=> !track_a_wr && !track_b_wr && !track_c_wr && (q.st == TTW_ERASE))
      else $error("Start did not clear the track flip-flops.");
   AST_ERASE_QUIET: assert property (@(posedge core_clk) disable iff (!rst_b)
      (q.st == TTW_ERASE) && !start |=> !track_a_wr && !track_b_wr && !track_c_wr)
      else $error("Track changed during erase.");
   AST_A_TOGGLE: assert property (@(posedge core_clk) disable iff (!rst_b)
      tick && !start |=> track_a_wr != $past(track_a_wr))
      else $error("Track A missed a toggle.");
   AST_ADDR_MARK: assert property (@(posedge core_clk) disable iff (!rst_b)
      tick && bit_count_decode_addr && !start |=> track_b_wr != $past(track_b_wr))
      else $error("Address marker not written.");
   AST_SYNC_ZERO: assert property (@(posedge core_clk) disable iff (!rst_b)
      tick && (q.word == WORD_ADDR) && (q.bitc == BIT_SYNC_ZERO) && !start |=> $stable(track_c_wr))
      else $error("Second sync bit toggled track C.");
   AST_BIT_WRAP: assert property (@(posedge core_clk) disable iff (!rst_b)
      tick && (q.bitc == BIT_LAST) && !start && !stop |=> (q.bitc == '0) && (q.word == $past(q.word) + 6'h01))
      else $error("Bit counter did not wrap into the next word.");
   AST_BLOCK_END: assert property (@(posedge core_clk) disable iff (!rst_b)
      block_end && !start |=> (q.bitc == '0) && (q.word == '0) && q.timing_marks_active)
      else $error("Block end did not clear the counters.");
   AST_FINAL: assert property (@(posedge core_clk) disable iff (!rst_b)
      final_sector_done && !start |=> (q.st == TTW_HOLD) && !q.write_permit)
      else $error("Final sector did not end the write.");

   // ****************************************
   // Sector, holdoff and erase checks
   // ****************************************
   // Each tick may change tracks B and C only in the slots that belong to them.
   AST_B_ONLY_MARKS: assert property (@(posedge core_clk) disable iff (!rst_b)
      tick && !bit_count_decode_addr && !bit_count_decode_data && !start |=> $stable(track_b_wr))
      else $error("Track B changed outside a marker slot.");
   AST_C_ONLY_SLOTS: assert property (@(posedge core_clk) disable iff (!rst_b)
      tick && !c_slot && !start |=> $stable(track_c_wr))
      else $error("Track C changed outside its nine slots.");
   AST_MARKS_IDLE: assert property (@(posedge core_clk) disable iff (!rst_b)
      tick && !q.timing_marks_active && !start |=> $stable(track_b_wr) && $stable(track_c_wr))
      else $error("Track B or C written before marks were active.");

   AST_SYNC_ONE: assert property (@(posedge core_clk) disable iff (!rst_b)
      tick && c_slot && (q.word == WORD_ADDR) && (q.bitc == BIT_SYNC_ONE) && !start |=> track_c_wr != $past(track_c_wr))
      else $error("First sync bit not written.");
   // The address bit is taken from the address register, not from the shift register.
   AST_ADDR_BIT: assert property (@(posedge core_clk) disable iff (!rst_b)
      tick && address_output_window && !start |=> track_c_wr == ($past(track_c_wr) ^ $past(addr_bit)))
      else $error("Address bit on track C is wrong.");
   AST_PARITY: assert property (@(posedge core_clk) disable iff (!rst_b)
      tick && parity_slot && !start |=> (track_c_wr != $past(track_c_wr)) != $past(^q.addr))
      else $error("Parity bit does not make the address odd.");
   AST_DATA_MARK: assert property (@(posedge core_clk) disable iff (!rst_b)
      tick && bit_count_decode_data && !start |=> track_b_wr != $past(track_b_wr))
      else $error("Data marker not written.");

   AST_PULSE_QUIET: assert property (@(posedge core_clk) disable iff (!rst_b)
      (q.st == TTW_RUN) || (q.st == TTW_ERASE) |=> !q.track_a_pulse)
      else $error("Track A pulse raised while writing.");
   AST_STOP: assert property (@(posedge core_clk) disable iff (!rst_b)
      stop && !start |=> (q.st == TTW_HOLD) && !write_gate)
      else $error("Stop did not end the write.");
   AST_HOLD_LEN: assert property (@(posedge core_clk) disable iff (!rst_b)
      (q.st == TTW_HOLD) && !start |=> (q.st == TTW_IDLE) == ($past(q.cnt) == CNT_W'(HOLDOFF_CYCLES - 1)))
      else $error("Read holdoff has the wrong length.");
   AST_HOLD_NO_PERMIT: assert property (@(posedge core_clk) disable iff (!rst_b)
      (q.st == TTW_HOLD) |-> !q.write_permit)
      else $error("Write permit set during holdoff.");

   AST_ERASE_LEN: assert property (@(posedge core_clk) disable iff (!rst_b)
      (q.st == TTW_ERASE) && !start && !stop |=> (q.st == TTW_RUN) == ($past(q.cnt) == CNT_W'(ERASE_CYCLES - 1)))
      else $error("Erase interval has the wrong length.");
   AST_GATE_OFF: assert property (@(posedge core_clk) disable iff (!rst_b)
      (q.st == TTW_IDLE) || (q.st == TTW_HOLD) |-> !write_gate)
      else $error("Write gate open outside a write.");
   AST_ADDR_STEP: assert property (@(posedge core_clk) disable iff (!rst_b)
      block_end && q.timing_marks_active && !start |=> q.addr == $past(q.addr) + 6'h01)
      else $error("Block address did not advance.");

   COV_PARITY: cover property (@(posedge core_clk) disable iff (!rst_b) tick && parity_slot && !(^q.addr));
   COV_RUN: cover property (@(posedge core_clk) disable iff (!rst_b) $rose(q.timing_marks_active));
   COV_FINAL: cover property (@(posedge core_clk) disable iff (!rst_b) final_sector_done);
endmodule

// ---- core/ttw_pkg.sv ----
package ttw_pkg;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_MHZ = 200;
   localparam int ERASE_TIME_MS = 50;
   localparam int HOLDOFF_TIME_US = 200;
   localparam int WIN_A_TIME_US = 250;
   localparam int WIN_B_TIME_US = 350;
   localparam int ERASE_CYC = ERASE_TIME_MS * 1000 * CLK_MHZ;
   localparam int HOLDOFF_CYC = HOLDOFF_TIME_US * CLK_MHZ;
   localparam int WIN_A_CYC = WIN_A_TIME_US * CLK_MHZ;
   localparam int WIN_B_CYC = WIN_B_TIME_US * CLK_MHZ;
   localparam int BIT_DIV_CYC = 16;
   localparam int CNT_W = 24;

   // ****************************************
   // Sector layout
   // ****************************************
   localparam logic [4:0] BIT_LAST = 5'h11;
   localparam logic [4:0] BIT_EOB = 5'h05;
   localparam logic [4:0] BIT_ADDR_MARK = 5'h06;
   localparam logic [4:0] BIT_SYNC_ONE = 5'h0c;
   localparam logic [4:0] BIT_SYNC_ZERO = 5'h0d;
   localparam logic [4:0] BIT_WIN_FIRST = 5'h0e;
   localparam logic [4:0] BIT_WIN_LAST = 5'h01;
   localparam logic [4:0] BIT_PARITY = 5'h03;
   localparam logic [4:0] BIT_DATA_MARK = 5'h09;
   localparam logic [5:0] WORD_ADDR = 6'h00;
   localparam logic [5:0] WORD_DATA = 6'h01;
   localparam logic [5:0] WORD_LAST = 6'h23;
   localparam logic [5:0] ADDR_LAST = 6'h3f;

   // ****************************************
   // Register port
   // ****************************************
   localparam int BUS_AW = 4;
   localparam logic [3:0] CTRL_OFS = 4'h0;
   localparam logic [3:0] STAT_OFS = 4'h4;
   localparam logic [3:0] POS_OFS = 4'h8;
   localparam int CTRL_SW_BIT = 0;
   localparam int CTRL_START_BIT = 1;
   localparam logic CTRL_SW_RST = 1'b0;

   typedef enum logic [3:0] {
      TTW_IDLE = 4'b0001,
      TTW_ERASE = 4'b0010,
      TTW_RUN = 4'b0100,
      TTW_HOLD = 4'b1000
   } ttw_state_t;

endpackage

// ---- core/ttw_gap_if.sv ----
`timescale 1ns/100ps
interface ttw_gap_if;
   logic op_clear;
   logic write_permit;
   logic holdoff_active;
   logic track_a_pulse;
   logic too_small;
   logic in_range;
   logic too_large;
   logic seen;

   modport wr (output op_clear, output write_permit, output holdoff_active, output track_a_pulse,
               input too_small, input in_range, input too_large, input seen);
   modport gap (input op_clear, input write_permit, input holdoff_active, input track_a_pulse,
                output too_small, output in_range, output too_large, output seen);
endinterface

// ---- core/ttw_gap_check.sv ----
`timescale 1ns/100ps
module ttw_gap_check #(
   parameter int WIN_A_CYCLES = ttw_pkg::WIN_A_CYC,
   parameter int WIN_B_CYCLES = ttw_pkg::WIN_B_CYC
) (
   input wire logic core_clk,
   input wire logic rst_b,
   ttw_gap_if.gap g
);
   import ttw_pkg::*;

   typedef struct packed {
      logic prev_permit;
      logic armed;
      logic [CNT_W-1:0] cnt;
      logic seen;
      logic too_small;
      logic in_range;
      logic too_large;
   } ttw_gap_state_t;

   ttw_gap_state_t q;
   ttw_gap_state_t n;
   logic take;

   // ****************************************
   // Gap measurement
   // ****************************************
   always_comb begin
      n = q;
      n.prev_permit = g.write_permit;
      take = g.track_a_pulse && !g.holdoff_active && q.armed && !q.seen;
      if (q.armed && q.cnt != {CNT_W{1'b1}}) begin
         n.cnt = q.cnt + 1'b1;
      end
      if (q.prev_permit && !g.write_permit) begin
         n.armed = 1'b1;
         n.cnt = '0;
      end
      if (take) begin
         n.seen = 1'b1;
         if (q.cnt < CNT_W'(WIN_A_CYCLES)) begin
            n.too_small = 1'b1;
         end else if (q.cnt < CNT_W'(WIN_B_CYCLES)) begin
            n.in_range = 1'b1;
         end else begin
            n.too_large = 1'b1;
         end
      end
      if (g.op_clear) begin
         n = '0;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   assign g.seen = q.seen;
   assign g.too_small = q.too_small;
   assign g.in_range = q.in_range;
   assign g.too_large = q.too_large;

   // ****************************************
   // Checks
   // ****************************************
   AST_ONE_FLAG: assert property (@(posedge core_clk) disable iff (!rst_b)
      $onehot0({q.too_small, q.in_range, q.too_large}) && (q.seen == (q.too_small | q.in_range | q.too_large)))
      else $error("Gap result flags are not exclusive.");
   AST_HOLDOFF_BLOCK: assert property (@(posedge core_clk) disable iff (!rst_b)
      g.holdoff_active && !q.seen && !g.op_clear |=> !q.seen)
      else $error("Track A seen during read holdoff.");
   AST_SMALL: assert property (@(posedge core_clk) disable iff (!rst_b)
      take && q.cnt < CNT_W'(WIN_A_CYCLES) && !g.op_clear |=> q.too_small)
      else $error("Short gap not flagged too small.");
   AST_LARGE: assert property (@(posedge core_clk) disable iff (!rst_b)
      take && q.cnt >= CNT_W'(WIN_B_CYCLES) && !g.op_clear |=> q.too_large)
      else $error("Long gap not flagged too large.");
   AST_CLEAR: assert property (@(posedge core_clk) disable iff (!rst_b)
      g.op_clear |=> !q.seen && !q.too_small && !q.in_range && !q.too_large)
      else $error("Flags not cleared at operation start.");
   COV_OK: cover property (@(posedge core_clk) disable iff (!rst_b) $rose(q.in_range));
   COV_SMALL: cover property (@(posedge core_clk) disable iff (!rst_b) $rose(q.too_small));
endmodule

// ---- test/ttw_heads_model.sv ----
`timescale 1ns/100ps
// ****************************************
// Track A read-back seen through the heads
// ****************************************
module ttw_heads_model (
   input wire logic core_clk,
   input wire logic write_gate,
   input int gap_cyc,
   input wire logic noise_en,
   output logic track_a_readback = 1'b0
);
   int cnt = 0;
   logic armed = 1'b0;
   // After the write ends, timing comes back after the gap as a steady pulse train.
   // An optional noise burst from the heads switching off lands early in the holdoff.
   always @(posedge core_clk) begin
      if (write_gate === 1'b1) begin
         cnt <= 0;
         armed <= 1'b1;
         track_a_readback <= 1'b0;
      end else if (armed) begin
         cnt <= cnt + 1;
         track_a_readback <= (noise_en && cnt >= 2 && cnt < 4) || (cnt >= gap_cyc && (cnt - gap_cyc) % 8 < 4);
      end
   end
endmodule

// ---- test/ttw_top_tb.sv ----
`timescale 1ns/100ps
module ttw_top_tb;
   import ttw_pkg::*;
   localparam int ER = 20;
   localparam int BD = 2;
   logic core_clk;
   logic rst_b;
   logic [BUS_AW-1:0] reg_addr;
   logic [31:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [31:0] reg_rdata;
   logic track_a_readback, track_a_wr, track_b_wr, track_c_wr, write_gate;
   logic increase_lamp, ok_lamp, decrease_lamp;
   int fail_count = 0;
   int n_checks = 0;
   int gap_cyc = 40;
   logic noise_en = 1'b0;
   logic [31:0] seed = 32'h01e0;
   logic [31:0] rd;
   int cyc = 0;
   int w, b, ad, mk, fin, last, n;
   logic ea, eb, ec;

   ttw_top #(.ERASE_CYCLES(ER), .HOLDOFF_CYCLES(10), .WIN_A_CYCLES(30), .WIN_B_CYCLES(50), .BIT_DIV(BD)) dut (
      .core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .track_a_readback(track_a_readback), .track_a_wr(track_a_wr),
      .track_b_wr(track_b_wr), .track_c_wr(track_c_wr), .write_gate(write_gate),
      .increase_lamp(increase_lamp), .ok_lamp(ok_lamp), .decrease_lamp(decrease_lamp));

   ttw_heads_model heads (.core_clk(core_clk), .write_gate(write_gate), .gap_cyc(gap_cyc),
      .noise_en(noise_en), .track_a_readback(track_a_readback));

   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   // ****************************************
   // Checking and reporting
   // ****************************************
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         fail_count++;
         $display("CHECK FAILED at %0t: timeout", $time);
         final_report();
      end
   end

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task chk_reg(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task chk_bit(input logic got, input logic exp, input string what);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: %s got %b expected %b", $time, what, got, exp);
      end
   endtask

   task final_report();
      $display("Checks %0d, mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // ****************************************
   // Register port master
   // ****************************************
   task reg_write(input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask

   task reg_read(input logic [3:0] a, output logic [31:0] d);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(negedge core_clk);
      d = reg_rdata;
   endtask

   // ****************************************
   // Sector model: one call per bit clock
   // ****************************************
   task model_tick();
      ea = ~ea;
      if (mk != 0) begin
         if ((w == 0 && b == 6) || (w == 1 && b == 9)) eb = ~eb;
         if (w == 0 && b == 12) ec = ~ec;
         if (w == 0 && b >= 14) ec = ec ^ ad[b - 14];
         if (w == 1 && b <= 1) ec = ec ^ ad[b + 4];
         if (w == 1 && b == 3 && $countones(ad[5:0]) % 2 == 0) ec = ~ec;
      end
      if (w == 35 && b == 5) begin
         w = 0;
         b = 0;
         if (mk == 0) mk = 1;
         else if (ad == 63) fin = 1;
         else ad++;
      end else if (b == 17) begin
         b = 0;
         w++;
      end else begin
         b++;
      end
   endtask

   task wait_result(input logic [2:0] exp);
      for (int i = 0; i < 400 && increase_lamp !== 1'b1 && ok_lamp !== 1'b1 && decrease_lamp !== 1'b1; i++)
         @(negedge core_clk);
      repeat (3) @(negedge core_clk);
      chk_reg({29'h0, increase_lamp, ok_lamp, decrease_lamp}, {29'h0, exp}, "gap result");
   endtask

   task stop_test(input int g, input logic nz, input logic [2:0] exp);
      gap_cyc = g;
      noise_en = nz;
      reg_write(CTRL_OFS, 32'h3);
      repeat (2) @(negedge core_clk);
      chk_reg({29'h0, increase_lamp, ok_lamp, decrease_lamp}, 32'h0, "lamps cleared");
      repeat (ER + 40) @(negedge core_clk);
      reg_read(STAT_OFS, rd);
      chk_reg(rd & 32'h7f7, 32'h201, "run status");
      reg_read(CTRL_OFS, rd);
      chk_reg(rd, 32'h1, "control readback");
      reg_write(CTRL_OFS, 32'h0);
      repeat (2) @(negedge core_clk);
      ea = track_a_wr;
      repeat (8) begin
         @(negedge core_clk);
         chk_bit(track_a_wr, ea, "track a after stop");
      end
      chk_bit(write_gate, 1'b0, "gate after stop");
      wait_result(exp);
      $display("Stopped write with gap %0d done", g);
   endtask

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      rst_b = 1'b0;
      reg_addr = '0;
      reg_wdata = '0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      repeat (6) @(posedge core_clk);
      rst_b <= 1'b1;
      reg_read(STAT_OFS, rd);
      chk_reg(rd, 32'h80, "reset status");
      reg_read(POS_OFS, rd);
      chk_reg(rd, 32'h0, "reset position");
      seed = lfsr_next(seed);
      reg_write(STAT_OFS, seed);
      reg_write(4'hc, seed);
      reg_read(4'hc, rd);
      chk_reg(rd, 32'h0, "unmapped read");
      reg_write(CTRL_OFS, 32'h2);
      repeat (4) @(negedge core_clk);
      chk_bit(write_gate, 1'b0, "start with switch down");
      reg_read(STAT_OFS, rd);
      chk_reg(rd, 32'h80, "idle status");
      $display("Register test done");

      gap_cyc = 38;
      reg_write(CTRL_OFS, 32'h3);
      w = 0;
      b = 0;
      ad = 0;
      mk = 0;
      fin = 0;
      n = 0;
      ea = 1'b0;
      eb = 1'b0;
      ec = 1'b0;
      @(negedge core_clk);
      while (track_a_wr !== 1'b1 && n < ER + 10) begin
         chk_reg({28'h0, track_a_wr, track_b_wr, track_c_wr, write_gate}, 32'h1, "erase");
         @(negedge core_clk);
         n++;
      end
      chk_bit(n >= ER && n <= ER + 3, 1'b1, "erase length");
      last = cyc;
      while (fin == 0) begin
         if (track_a_wr !== ea) begin
            if (mk != 0 || w != 0 || b != 0) chk_reg(32'(cyc - last), 32'(BD), "bit period");
            last = cyc;
            model_tick();
         end
         chk_bit(track_a_wr, ea, "track a");
         chk_bit(track_b_wr, eb, "track b");
         chk_bit(track_c_wr, ec, "track c");
         if (fin == 0) @(negedge core_clk);
      end
      repeat (2) @(negedge core_clk);
      chk_bit(write_gate, 1'b0, "write end");
      reg_read(STAT_OFS, rd);
      chk_reg(rd & 32'h7f5, 32'h404, "holdoff status");
      wait_result(3'b010);
      $display("Full write done");

      seed = lfsr_next(seed);
      stop_test(12 + int'(seed[2:0]), 1'b0, 3'b100);
      seed = lfsr_next(seed);
      stop_test(60 + int'(seed[3:0]), 1'b1, 3'b001);
      seed = lfsr_next(seed);
      stop_test(34 + int'(seed[2:0]), 1'b0, 3'b010);
      final_report();
   end
endmodule
